// *** rtl/tam_top.sv ***
module tam_top
   import tam_pkg::*;
#(
   parameter int SLOTS = MAX_SLOTS
)
(
   input  wire logic                  core_clk_i,
   input  wire logic                  arst_n_i,
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr_i,
   input  wire logic                  s_axi_awvalid_i,
   output logic                       s_axi_awready_o,
   input  wire logic [31:0]           s_axi_wdata_i,
   input  wire logic [3:0]            s_axi_wstrb_i,
   input  wire logic                  s_axi_wvalid_i,
   output logic                       s_axi_wready_o,
   output logic [1:0]                 s_axi_bresp_o,
   output logic                       s_axi_bvalid_o,
   input  wire logic                  s_axi_bready_i,
   input  wire logic [ADDR_W-1:0]     s_axi_araddr_i,
   input  wire logic                  s_axi_arvalid_i,
   output logic                       s_axi_arready_o,
   output logic [31:0]                s_axi_rdata_o,
   output logic [1:0]                 s_axi_rresp_o,
   output logic                       s_axi_rvalid_o,
   input  wire logic                  s_axi_rready_i,
   input  wire tam_meas_s [NUM_SRC-1:0] meas_i,
   output logic [SLOTS-1:0]           first_alarm_direction_o,
   output logic [SLOTS-1:0]           second_alarm_direction_o,
   output logic [SLOTS-1:0]           meas_ok_o,
   output logic                       evt_valid_o,
   input  wire logic                  evt_ready_i,
   output tam_evt_s                   evt_o
);
   localparam int NE = SLOTS * NUM_EVT;
   localparam int IW = $clog2(NE);

   if (SLOTS < 1 || SLOTS > MAX_SLOTS)
   begin : g_bad_slots
      $error("SLOTS must be 1 to 16");
   end

   function automatic tam_wide_t to_fahr(input tam_temp_t c);
      logic signed [19:0] p;
      p = 20'(c);
      p = p * F_MUL / F_DIV + F_OFFSET;
      return p[17:0];
   endfunction : to_fahr

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      merge = old;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            merge[b*8 +: 8] = nw[b*8 +: 8];
   endfunction : merge

   function automatic logic [31:0] popcount(input logic [2*SLOTS-1:0] v);
      popcount = '0;
      for (int k = 0; k < 2*SLOTS; k++)
         popcount = popcount + 32'(v[k]);
   endfunction : popcount

   function automatic logic [IW-1:0] first_set(input logic [NE-1:0] v);
      first_set = '0;
      for (int k = NE-1; k >= 0; k--)
         if (v[k])
            first_set = IW'(k);
   endfunction : first_set

   // Reset release through two flops
   logic [1:0] rst_sync_reg;
   wire        rst_n = rst_sync_reg[1];

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         rst_sync_reg <= 2'h0;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end

   tam_cfg_s [SLOTS-1:0]        cfg_reg;
   logic [SLOTS-1:0][31:0]      thr_reg;
   logic [1:0]                  ctrl_reg;
   logic [31:0]                 count_reg;
   logic [31:0]                 stamp_now_reg;
   logic [SLOTS-1:0]            first_alarm_direction_reg;
   logic [SLOTS-1:0]            second_alarm_direction_reg;
   logic [SLOTS-1:0]            valid_reg;
   logic [NE-1:0]               pend_reg;
   logic [31:0]                 stamp_reg [NE];
   logic                        evt_valid_reg;
   tam_evt_s                    evt_reg;

   logic [SLOTS-1:0]            first_alarm_direction_next;
   logic [SLOTS-1:0]            second_alarm_direction_next;
   logic [SLOTS-1:0]            valid_next;
   logic [NE-1:0]               evt_set;
   logic [2*SLOTS-1:0]          alarm_rise;
   tam_wide_t [SLOTS-1:0]       meas_sc;

   wire [NUM_EVT-1:0] store_mask = {3{ctrl_reg[CTRL_STORE_OFF_BIT],
                                      ctrl_reg[CTRL_STORE_ON_BIT]}};

   for (genvar s = 0; s < SLOTS; s++)
   begin : g_sensor_slot
      tam_cfg_s  c;
      tam_meas_s m;
      logic      src_ok;
      logic [5:0] src_idx;
      tam_wide_t th1;
      tam_wide_t th2;
      logic      hit1;
      logic      hit2;
      logic [NUM_EVT-1:0] raw;
      assign c       = cfg_reg[s];
      // Module codes above the last external module select nothing
      assign src_ok  = 32'(c.module_sel) < NUM_MODULES;
      assign src_idx = src_ok ? {c.module_sel, c.chan} : 6'h00;
      assign m       = meas_i[src_idx];
      assign valid_next[s] = c.en & src_ok & m.comm_ok
                             & m.sensor_ok;
      assign meas_sc[s] = c.fahrenheit ? to_fahr(m.temp)
                                       : tam_wide_t'(m.temp);
      assign th1 = tam_wide_t'(signed'(thr_reg[s][THR1_LSB +: 16]));
      assign th2 = tam_wide_t'(signed'(thr_reg[s][THR2_LSB +: 16]));
      assign hit1 = c.first_alarm_direction ? (meas_sc[s] < th1)
                                            : (meas_sc[s] > th1);
      assign hit2 = c.second_alarm_direction ? (meas_sc[s] < th2)
                                             : (meas_sc[s] > th2);
      assign first_alarm_direction_next[s] = c.a1_en & valid_next[s] & hit1;
      assign second_alarm_direction_next[s] = c.a2_en & valid_next[s] & hit2;
      assign raw[EVT_A1_ON]    = first_alarm_direction_next[s] & ~first_alarm_direction_reg[s];
      assign raw[EVT_A1_OFF]   = ~first_alarm_direction_next[s] & first_alarm_direction_reg[s];
      assign raw[EVT_A2_ON]    = second_alarm_direction_next[s] & ~second_alarm_direction_reg[s];
      assign raw[EVT_A2_OFF]   = ~second_alarm_direction_next[s] & second_alarm_direction_reg[s];
      assign raw[EVT_MEAS_OK]  = valid_next[s] & ~valid_reg[s];
      assign raw[EVT_MEAS_BAD] = ~valid_next[s] & valid_reg[s];
      assign evt_set[s*NUM_EVT +: NUM_EVT] = raw & store_mask;
      assign alarm_rise[2*s +: 2] = {raw[EVT_A2_ON], raw[EVT_A1_ON]};
   end

   // Event selection, lowest slot and code first
   wire [IW-1:0] pick      = first_set(pend_reg);
   wire          take      = (|pend_reg) & (~evt_valid_reg | evt_ready_i);
   wire [NE-1:0] pend_clr  = take ? (NE'(1) << pick) : '0;

   // AXI write path
   logic               awready_reg;
   logic               wready_reg;
   logic               bvalid_reg;
   logic [1:0]         bresp_reg;
   logic [ADDR_W-1:0]  awaddr_reg;
   logic [31:0]        wdata_reg;
   logic [3:0]         wstrb_reg;
   logic               arready_reg;
   logic               rvalid_reg;
   logic [1:0]         rresp_reg;
   logic [31:0]        rdata_reg;

   wire        wr_go   = ~awready_reg & ~wready_reg & ~bvalid_reg;
   wire [1:0]  wr_reg  = awaddr_reg[7:6];
   wire [3:0]  wr_idx  = awaddr_reg[5:2];
   wire        wr_slot = 32'(wr_idx) < SLOTS;
   wire        wr_cfg  = wr_go & wr_slot & (wr_reg == REGION_CFG);
   wire        wr_thr  = wr_go & wr_slot & (wr_reg == REGION_THR);
   wire        wr_ctl  = wr_go & (wr_reg == REGION_CTL)
                         & (wr_idx == CTL_IDX_CTRL);
   wire        wr_map  = wr_slot & (wr_reg != REGION_CTL)
                         | (wr_reg == REGION_CTL)
                           & (wr_idx <= CTL_IDX_STAMP);
   wire [31:0] ctl_new = merge({30'h0, ctrl_reg}, wdata_reg, wstrb_reg);
   wire [31:0] cfg_new = merge(32'(cfg_reg[wr_idx]), wdata_reg, wstrb_reg);
   wire        cnt_clr = wr_ctl & ctl_new[CTRL_CNT_CLR_BIT];

   // AXI read path
   wire [1:0]  rd_reg  = s_axi_araddr_i[7:6];
   wire [3:0]  rd_idx  = s_axi_araddr_i[5:2];
   wire        rd_slot = 32'(rd_idx) < SLOTS;
   wire        rd_hs   = s_axi_arvalid_i & arready_reg;
   logic [31:0] rd_data;
   logic        rd_ok;

   always_comb
   begin
      rd_data = 32'h0;
      rd_ok   = rd_slot;
      case (rd_reg)
         REGION_CFG:  if (rd_slot) rd_data = 32'(cfg_reg[rd_idx]);
         REGION_THR:  if (rd_slot) rd_data = thr_reg[rd_idx];
         REGION_MEAS: if (rd_slot) rd_data = 32'(meas_sc[rd_idx]);
         default:
         begin
            rd_ok = 1'b1;
            case (rd_idx)
               CTL_IDX_CTRL:   rd_data = {30'h0, ctrl_reg};
               CTL_IDX_COUNT:  rd_data = count_reg;
               CTL_IDX_ALARMS: rd_data = (32'(second_alarm_direction_reg) << ALM2_LSB)
                                         | 32'(first_alarm_direction_reg);
               CTL_IDX_VALID:  rd_data = 32'(valid_reg);
               CTL_IDX_STAMP:  rd_data = stamp_now_reg;
               default:        rd_ok   = 1'b0;
            endcase
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
         awaddr_reg  <= '0;
         wdata_reg   <= 32'h0;
         wstrb_reg   <= 4'h0;
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OKAY;
         rdata_reg   <= 32'h0;
      end
      else
      begin
         if (s_axi_awvalid_i && awready_reg)
         begin
            awaddr_reg  <= s_axi_awaddr_i;
            awready_reg <= 1'b0;
         end
         if (s_axi_wvalid_i && wready_reg)
         begin
            wdata_reg  <= s_axi_wdata_i;
            wstrb_reg  <= s_axi_wstrb_i;
            wready_reg <= 1'b0;
         end
         if (wr_go)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_reg && s_axi_bready_i)
         begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
         if (rd_hs)
         begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_data;
            rresp_reg   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         if (rvalid_reg && s_axi_rready_i)
         begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_reg  <= {SLOTS{CFG_RST}};
         thr_reg  <= '0;
         ctrl_reg <= CTRL_RST;
      end
      else
      begin
         if (wr_cfg)
            cfg_reg[wr_idx] <= cfg_new[CFG_W-1:0];
         if (wr_thr)
            thr_reg[wr_idx] <= merge(thr_reg[wr_idx], wdata_reg,
                                     wstrb_reg);
         if (wr_ctl)
            ctrl_reg <= ctl_new[1:0];
      end
   end

   // Slot state, alarm counter and time base
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         first_alarm_direction_reg    <= '0;
         second_alarm_direction_reg    <= '0;
         valid_reg     <= '0;
         count_reg     <= 32'h0;
         stamp_now_reg <= 32'h0;
      end
      else
      begin
         first_alarm_direction_reg    <= first_alarm_direction_next;
         second_alarm_direction_reg    <= second_alarm_direction_next;
         valid_reg     <= valid_next;
         stamp_now_reg <= stamp_now_reg + 32'h1;
         // Activations in the clearing cycle survive the clear
         count_reg     <= (cnt_clr ? 32'h0 : count_reg)
                          + popcount(alarm_rise);
      end
   end

   // Pending events; a new set beats the clear of a taken one
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pend_reg      <= '0;
         evt_valid_reg <= 1'b0;
         evt_reg       <= '0;
      end
      else
      begin
         pend_reg <= (pend_reg & ~pend_clr) | evt_set;
         if (take)
         begin
            evt_valid_reg <= 1'b1;
            evt_reg.slot  <= 4'(32'(pick) / NUM_EVT);
            evt_reg.code  <= 3'(32'(pick) % NUM_EVT);
            evt_reg.stamp <= stamp_reg[pick];
         end
         else if (evt_ready_i)
            evt_valid_reg <= 1'b0;
      end
   end

   // Stamp caught in the cycle the change is seen
   always_ff @(posedge core_clk_i)
   begin
      for (int k = 0; k < NE; k++)
         if (evt_set[k])
            stamp_reg[k] <= stamp_now_reg;
   end

   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o  = wready_reg;
   assign s_axi_bvalid_o  = bvalid_reg;
   assign s_axi_bresp_o   = bresp_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_rvalid_o  = rvalid_reg;
   assign s_axi_rresp_o   = rresp_reg;
   assign s_axi_rdata_o   = rdata_reg;
   assign first_alarm_direction_o        = first_alarm_direction_reg;
   assign second_alarm_direction_o        = second_alarm_direction_reg;
   assign meas_ok_o       = valid_reg;
   assign evt_valid_o     = evt_valid_reg;
   assign evt_o           = evt_reg;
endmodule : tam_top

// *** rtl/tam_pkg.sv ***
// What this block does
// - Sixteen independent sensor slots, each with own source, thresholds, alarms.
// - Status goes invalid on source communication failure or broken sensor.
// - First alarm has its own enable, disabled after reset.
// - First alarm direction selects above or below; default above.
// - First threshold in tenth-degree steps, default zero; trips on crossing.
// - Second alarm has its own enable, disabled after reset, independent.
// - Second alarm own threshold and direction, defaults zero and above.
// - Per slot Celsius or Fahrenheit scale; comparison in chosen scale.
// - Separate alarm on/off and measurement ok/invalid events per slot.
// - Configuration selects storing on events, off events or both.
// - Each stored event carries time stamp taken at the status change.
// - Cumulative alarm activation counter, clearable by command.
// - Alarm states available as output signals for control and logic.
// - Slot selects channel zero to seven of its module, default zero.
// - Source among two internal and three external modules; enable gates slot.
package tam_pkg;
   localparam int MAX_SLOTS        = 16;
   localparam int NUM_MODULES      = 5;
   localparam int CHANS_PER_MODULE = 8;
   localparam int NUM_SRC          = NUM_MODULES * CHANS_PER_MODULE;
   localparam int NUM_EVT          = 6;
   localparam int ADDR_W           = 8;

   localparam logic [1:0] REGION_CFG  = 2'h0;
   localparam logic [1:0] REGION_THR  = 2'h1;
   localparam logic [1:0] REGION_CTL  = 2'h2;
   localparam logic [1:0] REGION_MEAS = 2'h3;
   localparam logic [3:0] CTL_IDX_CTRL   = 4'h0;
   localparam logic [3:0] CTL_IDX_COUNT  = 4'h1;
   localparam logic [3:0] CTL_IDX_ALARMS = 4'h2;
   localparam logic [3:0] CTL_IDX_VALID  = 4'h3;
   localparam logic [3:0] CTL_IDX_STAMP  = 4'h4;

   localparam int CTRL_STORE_ON_BIT  = 0;
   localparam int CTRL_STORE_OFF_BIT = 1;
   localparam int CTRL_CNT_CLR_BIT   = 2;
   localparam logic [1:0] CTRL_RST   = 2'h3;
   localparam int THR1_LSB = 0;
   localparam int THR2_LSB = 16;
   localparam int ALM2_LSB = 16;

   localparam logic [2:0] EVT_A1_ON   = 3'h0;
   localparam logic [2:0] EVT_A1_OFF  = 3'h1;
   localparam logic [2:0] EVT_A2_ON   = 3'h2;
   localparam logic [2:0] EVT_A2_OFF  = 3'h3;
   localparam logic [2:0] EVT_MEAS_OK = 3'h4;
   localparam logic [2:0] EVT_MEAS_BAD = 3'h5;

   localparam logic signed [19:0] F_MUL    = 20'sh00009;
   localparam logic signed [19:0] F_DIV    = 20'sh00005;
   localparam logic signed [19:0] F_OFFSET = 20'sh00140;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef logic signed [15:0] tam_temp_t;
   typedef logic signed [17:0] tam_wide_t;

   typedef struct packed {
      tam_temp_t temp;
      logic      comm_ok;
      logic      sensor_ok;
   } tam_meas_s;

   typedef struct packed {
      logic       second_alarm_direction;
      logic       a2_en;
      logic       first_alarm_direction;
      logic       a1_en;
      logic       fahrenheit;
      logic [2:0] chan;
      logic [2:0] module_sel;
      logic       en;
   } tam_cfg_s;

   localparam int       CFG_W   = $bits(tam_cfg_s);
   localparam tam_cfg_s CFG_RST = '0;

   typedef struct packed {
      logic [3:0]  slot;
      logic [2:0]  code;
      logic [31:0] stamp;
   } tam_evt_s;
endpackage : tam_pkg

// *** verif/tam_meas_model.sv ***
module tam_meas_model
   import tam_pkg::*;
(
   input  wire logic                 core_clk_i,
   input  wire logic                 we_i,
   input  wire logic [5:0]           src_i,
   input  wire tam_meas_s            set_i,
   output tam_meas_s [NUM_SRC-1:0]   meas_o
);
   timeunit 1ns;
   timeprecision 1ps;
   tam_meas_s store [NUM_SRC] = '{default: '0};

   always @(posedge core_clk_i)
   begin
      if (we_i)
         store[src_i] <= set_i;
   end

   // A dead link carries no fresh data, so show a corrupted value
   for (genvar k = 0; k < NUM_SRC; k++)
   begin : g_src
      assign meas_o[k] = store[k].comm_ok ? store[k] :
         {~store[k].temp, 1'b0, store[k].sensor_ok};
   end
endmodule : tam_meas_model

// *** verif/tam_top_asserts.sv ***
module tam_top_asserts
   import tam_pkg::*;
#(
   parameter int SLOTS = MAX_SLOTS
)
(
   input wire logic             core_clk_i,
   input wire logic             arst_n_i,
   input wire logic             s_axi_awready_o,
   input wire logic             s_axi_wready_o,
   input wire logic [1:0]       s_axi_bresp_o,
   input wire logic             s_axi_bvalid_o,
   input wire logic             s_axi_bready_i,
   input wire logic             s_axi_arready_o,
   input wire logic [31:0]      s_axi_rdata_o,
   input wire logic             s_axi_rvalid_o,
   input wire logic             s_axi_rready_i,
   input wire logic [SLOTS-1:0] first_alarm_direction_o,
   input wire logic [SLOTS-1:0] second_alarm_direction_o,
   input wire logic [SLOTS-1:0] meas_ok_o,
   input wire logic             evt_valid_o,
   input wire logic             evt_ready_i,
   input wire tam_evt_s         evt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   AST_A1_VALID: assert property ((first_alarm_direction_o & ~meas_ok_o) == '0)
      else $error("first_alarm_direction active on invalid slot");
   AST_A2_VALID: assert property (!(|(second_alarm_direction_o & ~meas_ok_o)))
      else $error("second_alarm_direction active on invalid slot");
   AST_EVT_HOLD: assert property (evt_valid_o && !evt_ready_i |=>
      evt_valid_o && $stable(evt_o))
      else $error("event changed before taken");
   AST_EVT_CODE: assert property (evt_valid_o |->
      evt_o.code <= EVT_MEAS_BAD)
      else $error("event code out of range");
   AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o))
      else $error("write response dropped early");
   AST_B_DONE: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
      !s_axi_bvalid_o)
      else $error("write response repeated");
   AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data dropped early");
   AST_W_REFUSE: assert property (s_axi_bvalid_o |->
      !s_axi_awready_o && !s_axi_wready_o)
      else $error("write accepted while response pending");
   AST_R_REFUSE: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("read accepted while data pending");
endmodule : tam_top_asserts

// *** verif/tam_top_bench.sv ***
module tam_top_bench
   import tam_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0, arst_n_i = 1'b0;
   logic [7:0]  s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
   logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
   logic [3:0]  s_axi_wstrb_i = 4'hf;
   logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
   logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0, evt_ready_i = 0;
   logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   logic        s_axi_arready_o, s_axi_rvalid_o, evt_valid_o, we = 0;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rs;
   logic [15:0] first_alarm_direction_o, second_alarm_direction_o, meas_ok_o, pa1 = '0, pa2 = '0;
   logic [31:0] rd;
   logic [5:0]  src = '0;
   tam_meas_s   set = '0;
   tam_meas_s [NUM_SRC-1:0] meas_i;
   tam_evt_s    evt_o;
   integer      seed = 32'hfaf7, seed2 = 32'hfaf7;
   int          bad_count = 0, tests_run = 0, rises = 0;
   int          on_seen = 0, off_seen = 0;
   int          falls = 0, on_exp = 0, cur = 0;
   logic [31:0] last_stamp = '0;
   logic        got_evt = 1'b0;
   logic [1:0]  wr_resp = '0;

   always #12.5 core_clk_i = ~core_clk_i;

   tam_top i_dut (.core_clk_i, .arst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
      .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
      .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
      .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
      .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .meas_i, .first_alarm_direction_o,
      .second_alarm_direction_o, .meas_ok_o, .evt_valid_o, .evt_ready_i, .evt_o);
   tam_meas_model i_src (.core_clk_i, .we_i(we), .src_i(src), .set_i(set),
      .meas_o(meas_i));

   // Random stalls on the event side so the hold logic is exercised
   always @(posedge core_clk_i)
   begin
      evt_ready_i <= 1'($random(seed2));
      if (evt_valid_o && evt_ready_i)
      begin
         check("evt_slot", 32'(evt_o.slot), 32'(cur));
         last_stamp = evt_o.stamp;
         got_evt = 1'b1;
         on_seen += int'(evt_o.code == EVT_A1_ON || evt_o.code == EVT_A2_ON);
         off_seen += int'(evt_o.code == EVT_A1_OFF || evt_o.code == EVT_A2_OFF);
      end
   end

   task automatic finish_test;
      $display("Comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   task automatic hang;
      bad_count++;
      $display("MISMATCH wait expected done seen timeout");
      finish_test;
   endtask : hang

   task automatic check(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      for (int n = 0; n < 100; n++)
      begin
         @(posedge core_clk_i);
         if (s_axi_awready_o && s_axi_awvalid_i) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o && s_axi_wvalid_i) s_axi_wvalid_i <= 1'b0;
         if (s_axi_bvalid_o)
         begin
            wr_resp = s_axi_bresp_o;
            s_axi_bready_i <= 1'b0;
            return;
         end
      end
      hang();
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge core_clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      for (int n = 0; n < 100; n++)
      begin
         @(posedge core_clk_i);
         if (s_axi_arready_o && s_axi_arvalid_i) s_axi_arvalid_i <= 1'b0;
         if (s_axi_rvalid_o)
         begin
            d = s_axi_rdata_o;
            r = s_axi_rresp_o;
            s_axi_rready_i <= 1'b0;
            return;
         end
      end
      hang();
   endtask : axi_rd

   task automatic settle;
      repeat (3) @(posedge core_clk_i);
      for (int n = 0; n < 300 && evt_valid_o; n++) @(posedge core_clk_i);
      if (evt_valid_o) hang();
   endtask : settle

   function automatic logic signed [17:0] scale(input logic signed [15:0] c,
                                                input logic f);
      return f ? 18'((c * 9) / 5 + 320) : 18'(c);
   endfunction : scale

   function automatic logic alm(input logic en, ok, lo,
                                input logic signed [17:0] m, t);
      return en & ok & (lo ? m < t : m > t);
   endfunction : alm

   task automatic chk(input int s, input logic [11:0] cf, input logic ok,
                      input logic signed [17:0] m, t1, t2);
      logic [15:0] v, a1, a2;
      v = '0;
      a1 = '0;
      a2 = '0;
      v[s] = cf[0] & ok;
      a1[s] = alm(cf[8], v[s], cf[9], m, t1);
      a2[s] = alm(cf[10], v[s], cf[11], m, t2);
      check("meas_ok", {16'h0, meas_ok_o}, {16'h0, v});
      check("first_alarm_direction", {16'h0, first_alarm_direction_o}, {16'h0, a1});
      check("second_alarm_direction", {16'h0, second_alarm_direction_o}, {16'h0, a2});
      rises += $countones(a1 & ~pa1) + $countones(a2 & ~pa2);
      falls += $countones(~a1 & pa1) + $countones(~a2 & pa2);
      pa1 = a1;
      pa2 = a2;
      // Stamp must trail the live time base by the drain time only
      if (got_evt)
      begin
         axi_rd(8'h90, rd, rs);
         check("stamp", {31'h0, rd - last_stamp < 32'd200}, 32'h1);
         got_evt = 1'b0;
      end
      if (v[s])
      begin
         axi_rd(8'(8'hc0 + s * 4), rd, rs);
         check("meas", rd, 32'(m));
      end
   endtask : chk

   task automatic run_slot(input int s);
      logic [11:0] cf;
      logic signed [15:0] c, t1, t2;
      logic ok, b;
      cur = s;
      src = 6'($unsigned($random(seed)) % 40);
      cf = {5'($random(seed)), src[2:0], src[5:3], 1'b0};
      c = 16'($random(seed) % 1500);
      t1 = 16'(scale(c, cf[7]) + $random(seed) % 3);
      t2 = 16'(scale(c, cf[7]) + $random(seed) % 3);
      axi_wr(8'(8'h40 + s * 4), {t2, t1});
      // Source set before enabling so no untracked alarm edge appears
      for (int k = 0; k < 4; k++)
      begin
         if (k % 2)
         begin
            cf[0] = ~cf[0];
            axi_wr(8'(s * 4), {20'h0, cf});
         end
         else
         begin
            if (k == 2) c = c + 16'($random(seed) % 3);
            ok = ($random(seed) % 4) != 0;
            b = 1'($random(seed));
            @(posedge core_clk_i);
            set <= '{c, ok | b, ok | ~b};
            we <= 1'b1;
            @(posedge core_clk_i);
            we <= 1'b0;
         end
         settle();
         chk(s, cf, ok, scale(c, cf[7]), t1, t2);
      end
      $display("Slot %0d done", s);
   endtask : run_slot

   initial
   begin
      repeat (20) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      axi_rd(8'h80, rd, rs);
      check("ctrl", rd, 32'h3);
      axi_rd(8'h14, rd, rs);
      check("cfg", rd, 32'h0);
      axi_rd(8'h54, rd, rs);
      check("thr", rd, 32'h0);
      axi_rd(8'ha0, rd, rs);
      check("resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
      axi_wr(8'h80, 32'h1);
      check("bresp", {30'h0, wr_resp}, {30'h0, RESP_OKAY});
      axi_wr(8'ha0, 32'h0);
      check("bresp_bad", {30'h0, wr_resp}, {30'h0, RESP_SLVERR});
      s_axi_wstrb_i <= 4'h3;
      axi_wr(8'h40, 32'haaaa5555);
      s_axi_wstrb_i <= 4'hf;
      axi_rd(8'h40, rd, rs);
      check("strobe", rd, 32'h5555);
      for (int i = 0; i < 64; i++)
      begin
         // Second half stores only off events
         if (i == 32)
         begin
            axi_wr(8'h80, 32'h2);
            on_exp = rises;
            falls = 0;
         end
         run_slot(i % 16);
      end
      settle();
      axi_rd(8'h84, rd, rs);
      check("count", rd, 32'(rises));
      check("on_evt", 32'(on_seen), 32'(on_exp));
      check("off_evt", 32'(off_seen), 32'(falls));
      axi_wr(8'h80, 32'h5);
      axi_rd(8'h84, rd, rs);
      check("clear", rd, 32'h0);
      finish_test();
   end
endmodule : tam_top_bench

bind tam_top tam_top_asserts #(.SLOTS(SLOTS)) i_chk (.core_clk_i, .arst_n_i,
   .s_axi_awready_o, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
   .s_axi_bready_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
   .s_axi_rready_i, .first_alarm_direction_o, .second_alarm_direction_o, .meas_ok_o, .evt_valid_o,
   .evt_ready_i, .evt_o);
